// *** src/dpc_top.sv ***
// Dual PLL divider, loop configuration and reset/calibration sequencer
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_cfg.svh"
module dpc_top
  import dpc_pkg::*;
#(
  parameter int RST_TIMER_REF = `DPC_RST_TIMER_REF
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [11:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Pins and analog status
  input wire logic I_POWER_DOWN_N,
  input wire logic I_SUPPLY_GOOD,
  input wire logic I_PRI_REF,
  input wire logic I_SEC_REF,
  input wire logic [1:0] I_VCO_TICK,
  input wire logic [1:0] I_CAL_DONE,
  input wire logic [1:0] I_CAL_OK,
  // Analog core controls, two PLLs packed
  output logic [1:0] O_PFD_REF,
  output logic [1:0] O_PFD_FB,
  output logic [7:0] O_CP_SLICE,
  output logic [15:0] O_LF_R2,
  output logic [15:0] O_LF_C1,
  output logic [15:0] O_LF_R3,
  output logic [15:0] O_LF_C3,
  output logic [1:0] O_FRAC_FILT,
  output logic [5:0] O_FILT_ORDER,
  output logic [1:0] O_LOW_BW,
  output logic [1:0] O_CAL_START,
  output logic [1:0] O_PLL_RELEASE,
  output logic [7:0] O_MUTE
);
  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] ctrl_r;
  logic [7:0] mute_en_r;
  logic [7:0] bank_r [2][16];
  logic [7:0] def_img [16];
  dpc_state_t state_r;
  logic [1:0] done_r;
  logic pdn_q_r;
  logic srst_q_r;
  logic [15:0] tmr_r;
  logic reset_req;
  // Bus phase capture
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic acc_ok;
  logic [31:0] rd_nxt;

  // Pin-mode default image, reloaded while the power-down pin is low
  always_comb
  begin
    for (int k = 0; k < 16; k++)
    begin
      def_img[k] = `DPC_DEF_ZERO;
    end
    def_img[`DPC_IX_INT_HI] = `DPC_DEF_INT_HI;
    def_img[`DPC_IX_INT_HI + 1] = `DPC_DEF_INT_LO;
    def_img[`DPC_IX_DEN_LO] = `DPC_DEF_DEN_LO;
    def_img[`DPC_IX_REFDIV] = `DPC_DEF_REFDIV;
    def_img[`DPC_IX_INDIV] = `DPC_DEF_INDIV;
    def_img[`DPC_IX_CP] = `DPC_DEF_CP;
    def_img[`DPC_IX_FILT] = `DPC_DEF_FILT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  assign acc_ok = I_HSEL && I_HREADY && I_HTRANS[1];
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  // Write is performed in the data phase, when hwdata stands
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end
    else if (I_HREADY)
    begin
      wr_pend_r <= acc_ok && I_HWRITE;
      wr_addr_r <= I_HADDR;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_nxt = 32'h00000000;
    if (I_HADDR == `DPC_ADDR_CTRL)
    begin
      rd_nxt = {24'h000000, ctrl_r};
    end
    else if (I_HADDR == `DPC_ADDR_STAT)
    begin
      rd_nxt = {24'h000000, O_PLL_RELEASE, O_CAL_START, done_r, state_r};
    end
    else if (I_HADDR == `DPC_ADDR_MUTE)
    begin
      rd_nxt = {24'h000000, mute_en_r};
    end
    else if (I_HADDR >= `DPC_ADDR_PLL0 && I_HADDR < `DPC_ADDR_PLL0 + 2 * `DPC_PLL_STRIDE)
    begin
      rd_nxt = {24'h000000, bank_r[I_HADDR[7]][I_HADDR[5:2]]};
    end
  end

  // Read data registered at the address phase edge
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_HRDATA <= 32'h00000000;
    end
    else if (acc_ok && !I_HWRITE)
    begin
      O_HRDATA <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global control and mute-enable registers
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      ctrl_r <= `DPC_CTRL_RST;
      mute_en_r <= `DPC_MUTE_RST;
    end
    else if (wr_pend_r && wr_addr_r == `DPC_ADDR_CTRL)
    begin
      ctrl_r <= I_HWDATA[7:0]; // Soft reset bit resets high; writing it low holds reset
    end
    else if (wr_pend_r && wr_addr_r == `DPC_ADDR_MUTE)
    begin
      mute_en_r <= I_HWDATA[7:0];
    end
  end

  // Per-PLL banks: zeros on system reset, defaults while the pin holds reset
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      for (int p = 0; p < 2; p++)
      begin
        for (int k = 0; k < 16; k++)
        begin
          bank_r[p][k] <= 8'h00;
        end
      end
    end
    else if (!I_POWER_DOWN_N || !pdn_q_r)
    begin
      for (int p = 0; p < 2; p++)
      begin
        for (int k = 0; k < 16; k++)
        begin
          bank_r[p][k] <= def_img[k]; // Pin-mode image reload
        end
      end
    end
    else if (wr_pend_r && wr_addr_r >= `DPC_ADDR_PLL0
             && wr_addr_r < `DPC_ADDR_PLL0 + 2 * `DPC_PLL_STRIDE)
    begin
      bank_r[wr_addr_r[7]][wr_addr_r[5:2]] <= I_HWDATA[7:0]; // Soft reset keeps these
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference edge detection and doublers
  logic pri_q_r;
  logic sec_q_r;
  logic pri_tick;
  logic sec_tick;
  logic [1:0] rdiv_tick;
  logic [1:0] mux_tick;
  logic [15:0] los_r [2];

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      pri_q_r <= 1'b0;
      sec_q_r <= 1'b0;
    end
    else
    begin
      pri_q_r <= I_PRI_REF;
      sec_q_r <= I_SEC_REF;
    end
  end

  // Doubler counts both edges instead of rising only
  assign pri_tick = ctrl_r[`DPC_CTRL_PDBL] ? (I_PRI_REF ^ pri_q_r) : (I_PRI_REF & ~pri_q_r);
  assign sec_tick = ctrl_r[`DPC_CTRL_SDBL] ? (I_SEC_REF ^ sec_q_r) : (I_SEC_REF & ~sec_q_r);

  // Per-PLL chain: reference divider, smart mux, input and feedback dividers
  for (genvar p = 0; p < 2; p++)
  begin : g_pll
    logic use_sec;
    logic fb_tick;

    dpc_div #(.W(3)) u_rdiv (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_tick(pri_tick),
      .i_ratio(bank_r[p][`DPC_IX_REFDIV][2:0]),
      .o_tick(rdiv_tick[p])
    ); // Free-running on the primary reference

    // Loss window on the divided primary, used only for auto switching
    always_ff @(posedge I_CLK or posedge I_SYS_RST)
    begin
      if (I_SYS_RST)
      begin
        los_r[p] <= 16'h0000;
      end
      else if (rdiv_tick[p])
      begin
        los_r[p] <= 16'h0000;
      end
      else if (los_r[p] != `DPC_LOS_CYC)
      begin
        los_r[p] <= los_r[p] + 16'h0001;
      end
    end

    // Auto switch trusts software to keep the two within 2000 ppm
    assign use_sec = bank_r[p][`DPC_IX_FILT][`DPC_FILT_SEC]
                     || (bank_r[p][`DPC_IX_FILT][`DPC_FILT_AUTO] && los_r[p] == `DPC_LOS_CYC);
    assign mux_tick[p] = use_sec ? sec_tick : rdiv_tick[p];

    dpc_div #(.W(5)) u_mdiv (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_tick(mux_tick[p]),
      .i_ratio(bank_r[p][`DPC_IX_INDIV][4:0]),
      .o_tick(O_PFD_REF[p])
    ); // Input divider after the mux

    // Eight consecutive entries: INT hi/lo, NUM hi/mid/lo, FRACTION_DENOMINATOR hi/mid/lo
    dpc_fbdiv u_fbdiv (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_run(O_PLL_RELEASE[p]),
      .i_int({bank_r[p][0], bank_r[p][1]}),
      .i_num({bank_r[p][2][5:0], bank_r[p][3], bank_r[p][4]}),
      .i_den({bank_r[p][5][5:0], bank_r[p][6], bank_r[p][7]}),
      .i_tick(I_VCO_TICK[p]),
      .o_tick(fb_tick)
    ); // Fractional feedback
    assign O_PFD_FB[p] = fb_tick;

    // Loop settings straight from their own bank entries
    assign O_CP_SLICE[4*p +: 4] = bank_r[p][`DPC_IX_CP][3:0];
    assign O_LF_R2[8*p +: 8] = bank_r[p][`DPC_IX_R2];
    assign O_LF_C1[8*p +: 8] = bank_r[p][`DPC_IX_R2 + 1];
    assign O_LF_R3[8*p +: 8] = bank_r[p][`DPC_IX_R3];
    assign O_LF_C3[8*p +: 8] = bank_r[p][`DPC_IX_R3 + 1];
    // Filter mode bits are passed as written; software picks them
    assign O_FRAC_FILT[p] = bank_r[p][`DPC_IX_R3][0];
    assign O_FILT_ORDER[3*p +: 3] = bank_r[p][`DPC_IX_FILT][2:0];
    assign O_LOW_BW[p] = bank_r[p][`DPC_IX_FILT][`DPC_FILT_LBW];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources; previous levels kept to see the low-to-high return
  assign reset_req = !I_POWER_DOWN_N || !ctrl_r[`DPC_CTRL_SRST];

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      pdn_q_r <= 1'b0;
      srst_q_r <= 1'b0;
    end
    else
    begin
      pdn_q_r <= I_POWER_DOWN_N;
      srst_q_r <= ctrl_r[`DPC_CTRL_SRST];
    end
  end

  // Sequencer: reset, settle on supplies and timer, calibrate, run
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_r <= DPC_ST_RESET;
      tmr_r <= 16'h0000;
      done_r <= 2'b00;
    end
    else if (reset_req)
    begin
      state_r <= DPC_ST_RESET;
      tmr_r <= 16'h0000;
      done_r <= 2'b00;
    end
    else
    begin
      case (state_r)
        DPC_ST_RESET:
        begin
          // Power-up and either return to high both land here
          state_r <= DPC_ST_SETTLE;
          tmr_r <= 16'h0000;
        end
        DPC_ST_SETTLE:
        begin
          // Timer counts reference edges, so a dead reference stalls here
          if (pri_tick && tmr_r < 16'(RST_TIMER_REF))
          begin
            tmr_r <= tmr_r + 16'h0001;
          end
          if (I_SUPPLY_GOOD && tmr_r >= 16'(RST_TIMER_REF))
          begin
            state_r <= DPC_ST_CAL;
            done_r <= 2'b00;
          end
        end
        DPC_ST_CAL:
        begin
          done_r <= done_r | I_CAL_DONE;
          if ((I_CAL_DONE & ~I_CAL_OK) != 2'b00)
          begin
            state_r <= DPC_ST_SETTLE; // Failed pass retries after settling again
            tmr_r <= 16'h0000;
          end
          else if ((done_r | I_CAL_DONE) == 2'b11)
          begin
            state_r <= DPC_ST_RUN;
          end
        end
        DPC_ST_RUN:
        begin
          state_r <= DPC_ST_RUN;
        end
        default:
        begin
          state_r <= DPC_ST_RESET;
        end
      endcase
    end
  end

  // Calibration start, loop release and output muting
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_CAL_START <= 2'b00;
      O_PLL_RELEASE <= 2'b00;
      O_MUTE <= 8'h00;
    end
    else
    begin
      O_CAL_START <= (state_r == DPC_ST_CAL && !reset_req) ? ~done_r : 2'b00;
      O_PLL_RELEASE <= (state_r == DPC_ST_RUN && !reset_req) ? 2'b11 : 2'b00;
      O_MUTE <= (state_r == DPC_ST_CAL) ? mute_en_r : 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** src/dpc_cfg.svh ***
// Constants for the dual PLL divider and calibration control block
// Function
// - Each reference input has its own doubler, enabled by its own bit.
// - Free-running 3-bit reference divider on the primary reference feeds the input mux.
// - Auto input switching only when secondary is within 2000 ppm of divided primary; not checked here, left to software.
// - Per-PLL free-running 5-bit input divider after the input mux.
// - Feedback divider realises integer plus numerator over denominator, denominator 1..4194303.
// - Integer, numerator and denominator sit in eight consecutive registers per PLL.
// - Four-bit charge pump slice select per PLL, 0.4 mA to 6.4 mA.
// - R2, C1, R3 and C3 each have their own register, four per PLL.
// - Power-down pin low or soft reset bit at 0 puts the device in reset.
// - Reset exits on power-up or low-to-high return of either; calibration follows.
// - Leaving reset through the power-down pin reloads pin-mode defaults.
// - Soft reset bit reads high; low then high recalibrates keeping registers.
// - Calibration starts only when supplies are good and the reset timer expired.
// - Outputs with auto-mute enabled are muted while calibration runs.
// - After successful calibration the PLL is released to lock.
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH
// Global register byte addresses
`define DPC_ADDR_CTRL 12'h000
`define DPC_ADDR_STAT 12'h004
`define DPC_ADDR_MUTE 12'h008
`define DPC_ADDR_PLL0 12'h040
`define DPC_PLL_STRIDE 12'h040
// Control register fields
`define DPC_CTRL_SRST 0
`define DPC_CTRL_PDBL 1
`define DPC_CTRL_SDBL 2
`define DPC_CTRL_RST 8'h01
`define DPC_MUTE_RST 8'hff
// Per-PLL bank indices
`define DPC_IX_INT_HI 0
`define DPC_IX_DEN_LO 7
`define DPC_IX_R2 8
`define DPC_IX_R3 10
`define DPC_IX_REFDIV 12
`define DPC_IX_INDIV 13
`define DPC_IX_CP 14
`define DPC_IX_FILT 15
// Filter config fields
`define DPC_FILT_LBW 3
`define DPC_FILT_SEC 4
`define DPC_FILT_AUTO 5
// Pin-mode default image, one value for every bank entry
`define DPC_DEF_INT_HI 8'h00
`define DPC_DEF_INT_LO 8'h32
`define DPC_DEF_DEN_LO 8'h01
`define DPC_DEF_REFDIV 8'h01
`define DPC_DEF_INDIV 8'h01
`define DPC_DEF_CP 8'h04
`define DPC_DEF_FILT 8'h03
`define DPC_DEF_ZERO 8'h00
// Timing
`define DPC_RST_TIMER_REF 1024
`define DPC_LOS_CYC 16'h0100
`endif

// *** src/dpc_pkg.sv ***
// Types for the dual PLL divider and calibration control block
package dpc_pkg;
  // Sequencer states, Gray coded along reset, settle, calibrate, run
  typedef enum logic [1:0] {
    DPC_ST_RESET = 2'b00,
    DPC_ST_SETTLE = 2'b01,
    DPC_ST_CAL = 2'b11,
    DPC_ST_RUN = 2'b10
  } dpc_state_t;
endpackage

// *** src/dpc_div.sv ***
// Free-running tick divider used for the reference and input dividers
`timescale 1ns/1ps
`default_nettype none
module dpc_div #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Ticks in, ratio, ticks out
  input wire logic i_tick,
  input wire logic [W-1:0] i_ratio,
  output logic o_tick
);
  logic [W-1:0] cnt_r;
  logic wrap;

  // Ratio 0 and 1 both pass every tick; the counter never stops
  assign wrap = (cnt_r >= i_ratio - W'(1)) || (i_ratio == '0);

  // Counter runs continuously, no reload on ratio change
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= '0;
    end
    else if (i_tick)
    begin
      cnt_r <= wrap ? '0 : cnt_r + W'(1);
    end
  end

  // Output pulse registered
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= i_tick && wrap;
    end
  end
endmodule
`default_nettype wire

// *** src/dpc_fbdiv.sv ***
// Fractional feedback divider: N = INT + NUM / FRACTION_DENOMINATOR
`timescale 1ns/1ps
`default_nettype none
module dpc_fbdiv (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Divider hold while the loop is not released
  input wire logic i_run,
  // Settings
  input wire logic [15:0] i_int,
  input wire logic [21:0] i_num,
  input wire logic [21:0] i_den,
  // VCO ticks in, divided ticks out
  input wire logic i_tick,
  output logic o_tick
);
  logic [15:0] cnt_r;
  logic [15:0] tgt_r;
  logic [21:0] acc_r;
  logic [22:0] acc_sum;
  logic [21:0] den_eff;
  logic wrap;

  // A zero denominator is treated as one
  assign den_eff = (i_den == 22'h000000) ? 22'h000001 : i_den;
  assign acc_sum = {1'b0, acc_r} + {1'b0, i_num};
  assign wrap = i_tick && (cnt_r + 16'h0001 >= tgt_r);

  // Count to INT or INT+1 as the accumulator carries
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= 16'h0000;
      acc_r <= 22'h000000;
      tgt_r <= 16'h0001;
    end
    else if (!i_run)
    begin
      cnt_r <= 16'h0000;
      acc_r <= 22'h000000;
      tgt_r <= i_int;
    end
    else if (wrap)
    begin
      cnt_r <= 16'h0000;
      if (acc_sum >= {1'b0, den_eff})
      begin
        acc_r <= 22'(acc_sum - {1'b0, den_eff});
        tgt_r <= i_int + 16'h0001;
      end
      else
      begin
        acc_r <= acc_sum[21:0];
        tgt_r <= i_int;
      end
    end
    else if (i_tick)
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Divided output registered
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= wrap && i_run;
    end
  end
endmodule
`default_nettype wire

// *** tb/dpc_top_properties.sv ***
// Port-level checks for the PLL divider and calibration control block
`timescale 1ns/1ps
`default_nettype none
module dpc_top_properties #(
  parameter int RST_TIMER_REF = 4
) (
  // Clock, reset and pins
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_POWER_DOWN_N,
  input wire logic I_SUPPLY_GOOD,
  input wire logic I_PRI_REF,
  input wire logic [1:0] I_CAL_DONE,
  input wire logic [1:0] I_CAL_OK,
  // Outputs watched
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic [1:0] O_PFD_REF,
  input wire logic [1:0] O_PFD_FB,
  input wire logic [1:0] O_CAL_START,
  input wire logic [1:0] O_PLL_RELEASE,
  input wire logic [7:0] O_MUTE
);
  logic pri_q_r;
  logic [15:0] edges_r;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  ////////////////////////////////////////////////////////////
  // Reference edges since calibrate or run was last left; an upper bound on the timer
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      pri_q_r <= 1'b0;
      edges_r <= 16'h0000;
    end
    else
    begin
      pri_q_r <= I_PRI_REF;
      if (!I_POWER_DOWN_N || (O_CAL_START != 2'b00) || (O_PLL_RELEASE != 2'b00))
        edges_r <= 16'h0000;
      else if ((I_PRI_REF != pri_q_r) && (edges_r != 16'hffff))
        edges_r <= edges_r + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////
  // Bus answers are always immediate and okay
  a_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus answer not ready or not okay");
  a_pin_clears: assert property (!I_POWER_DOWN_N |-> ##2
    (O_CAL_START == 2'b00 && O_PLL_RELEASE == 2'b00 && O_MUTE == 8'h00))
    else $error("pin reset did not clear the sequencer outputs");
  a_cal_supply: assert property ($rose(O_CAL_START[0]) |-> $past(I_SUPPLY_GOOD, 2))
    else $error("calibration started without good supplies");
  a_cal_timer: assert property ($rose(O_CAL_START[0]) |->
    int'(edges_r) >= RST_TIMER_REF - 2)
    else $error("calibration started before the reset timer ran out");
  a_mute_norun: assert property (O_MUTE != 8'h00 |-> O_PLL_RELEASE == 2'b00)
    else $error("outputs muted while the loops are released");
  a_release_pair: assert property (O_PLL_RELEASE == 2'b00 || O_PLL_RELEASE == 2'b11)
    else $error("loops released one at a time");
  a_release_ok: assert property ($rose(O_PLL_RELEASE[0]) |->
    $past(|(I_CAL_DONE & I_CAL_OK), 2))
    else $error("loops released without a successful calibration");
  a_fb_run: assert property (O_PFD_FB[0] |-> (O_PLL_RELEASE[0] || $past(O_PLL_RELEASE[0])))
    else $error("feedback pulse while the loop is held");
  a_ref_pulse: assert property (O_PFD_REF[0] |=> !O_PFD_REF[0])
    else $error("input divider pulse longer than one cycle");
endmodule
bind dpc_top dpc_top_properties #(.RST_TIMER_REF(RST_TIMER_REF)) u_props (
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_POWER_DOWN_N(I_POWER_DOWN_N),
  .I_SUPPLY_GOOD(I_SUPPLY_GOOD), .I_PRI_REF(I_PRI_REF), .I_CAL_DONE(I_CAL_DONE),
  .I_CAL_OK(I_CAL_OK), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_PFD_REF(O_PFD_REF),
  .O_PFD_FB(O_PFD_FB), .O_CAL_START(O_CAL_START), .O_PLL_RELEASE(O_PLL_RELEASE),
  .O_MUTE(O_MUTE));
`default_nettype wire

// *** tb/dpc_core_model.sv ***
// Behavioural analog side: references, VCO ticks and calibration answers
`timescale 1ns/1ps
`default_nettype none
module dpc_core_model (
  // Clock, reset and behaviour knobs
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_fail,
  // Calibration requests
  input wire logic [1:0] i_cal_start,
  // References, ticks and answers
  output logic o_pri_ref,
  output logic o_sec_ref,
  output logic [1:0] o_vco_tick,
  output logic [1:0] o_cal_done,
  output logic [1:0] o_cal_ok
);
  logic [2:0] ph_r;
  logic [4:0] cal0_r;
  logic [4:0] cal1_r;
  logic [1:0] hit;
  ////////////////////////////////////////////////////////////
  // Six-cycle reference period, VCO tick every other cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ph_r <= 3'h0;
      o_vco_tick <= 2'b00;
    end
    else
    begin
      ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
      o_vco_tick <= ~o_vco_tick;
    end
  end
  assign o_pri_ref = (ph_r > 3'h2);
  assign o_sec_ref = ph_r[1];
  // Calibration time per loop; the second loop always finishes later
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cal0_r <= 5'h00;
      cal1_r <= 5'h00;
    end
    else
    begin
      cal0_r <= i_cal_start[0] ? cal0_r + {4'h0, !hit[0]} : 5'h00;
      cal1_r <= i_cal_start[1] ? cal1_r + {4'h0, !hit[1]} : 5'h00;
    end
  end
  assign hit[0] = (cal0_r == (i_slow ? 5'h0c : 5'h02));
  assign hit[1] = (cal1_r == (i_slow ? 5'h0e : 5'h04));
  // Result qualifier is meaningless outside done, so it wanders there
  assign o_cal_done = hit;
  assign o_cal_ok = (hit != 2'b00) ? {2{!i_fail}} : {2{ph_r[0]}};
endmodule
`default_nettype wire

// *** tb/dual_pll_divider_and_cal_control_bench.sv ***
// Self-checking bench for the PLL divider and calibration control block
`timescale 1ns/1ps
`default_nettype none
module dual_pll_divider_and_cal_control_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic power_down_n = 1'b0;
  logic sup = 1'b1;
  logic fail = 1'b0;
  logic slow = 1'b0;
  logic pri, sec, hready, hresp;
  logic [1:0] vco, cdone, cok, pref, pfb, cst, rel, ffilt, lbw;
  logic [7:0] cp, mute;
  logic [15:0] r2, c1, r3, c3;
  logic [5:0] ford;
  logic [31:0] hrdata, q;
  int n_errors = 0;
  int comparisons = 0;
  int cnt, c0, c1n, cf;
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // Design and analog side
  dpc_top #(.RST_TIMER_REF(4)) dut (.I_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .I_POWER_DOWN_N(power_down_n), .I_SUPPLY_GOOD(sup), .I_PRI_REF(pri),
    .I_SEC_REF(sec), .I_VCO_TICK(vco), .I_CAL_DONE(cdone), .I_CAL_OK(cok), .O_PFD_REF(pref),
    .O_PFD_FB(pfb), .O_CP_SLICE(cp), .O_LF_R2(r2), .O_LF_C1(c1), .O_LF_R3(r3), .O_LF_C3(c3),
    .O_FRAC_FILT(ffilt), .O_FILT_ORDER(ford), .O_LOW_BW(lbw), .O_CAL_START(cst),
    .O_PLL_RELEASE(rel), .O_MUTE(mute));
  dpc_core_model u_core (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_fail(fail),
    .i_cal_start(cst), .o_pri_ref(pri), .o_sec_ref(sec), .o_vco_tick(vco),
    .o_cal_done(cdone), .o_cal_ok(cok));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t ns: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int got, input int lo, input int hi);
    chk({31'h0, (got >= lo) && (got <= hi)}, 32'h1);
  endtask
  // One single transfer; address held until ready, then the data phase
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  // Bounded wait on the release (sel 0) or calibrate request (sel 1) of the first loop
  task automatic wait_for(input int sel, input logic v);
    cnt = 0;
    while ((((sel == 0) ? rel[0] : cst[0]) !== v) && (cnt < 500))
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk({31'h0, (sel == 0) ? rel[0] : cst[0]}, {31'h0, v});
  endtask
  // Pulses seen on both input dividers and the first feedback divider
  task automatic count(input int n);
    c0 = 0;
    c1n = 0;
    cf = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      c0 += int'(pref[0]);
      c1n += int'(pref[1]);
      cf += int'(pfb[0]);
    end
  endtask
  function automatic logic [31:0] dflt(input int i);
    case (i)
      1: return 32'h32;
      7, 12, 13: return 32'h01;
      14: return 32'h04;
      15: return 32'h03;
      default: return 32'h00;
    endcase
  endfunction
  task automatic results;
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog well beyond the few thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results;
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rc(12'h000, 32'h01);
    rc(12'h008, 32'hff);
    wr(12'h3fc, 32'h5a);
    rc(12'h3fc, 32'h00);
    power_down_n <= 1'b1;
    wait_for(1, 1'b1);
    chk({24'h0, mute}, 32'hff);
    wait_for(0, 1'b1);
    chk({24'h0, mute}, 32'h00);
    for (int i = 0; i < 32; i++)
      rc(12'h040 + 12'(4 * i), dflt(i % 16));
    chk({24'h0, cp}, 32'h44);
    // Loop settings land on the analog controls; upper data bits are dropped
    wr(12'h078, 32'hffffff0a);
    wr(12'h060, 32'h12);
    wr(12'h064, 32'h34);
    wr(12'h068, 32'h01);
    wr(12'h06c, 32'h78);
    wr(12'h07c, 32'h0f);
    wr(12'h0b8, 32'h05);
    wr(12'h0bc, 32'h03);
    rc(12'h078, 32'h0a);
    chk({24'h0, cp}, 32'h5a);
    chk({r2, c1}, 32'h00120034);
    chk({r3, c3}, 32'h00010078);
    chk({28'h0, ffilt, lbw}, 32'h5);
    chk({26'h0, ford}, 32'h1f);
    // Integer feedback ratio of four
    for (int i = 0; i < 8; i++)
      wr(12'h040 + 12'(4 * i), (i == 1) ? 32'h04 : (i == 7) ? 32'h01 : 32'h00);
    // Let the old ratio of fifty finish its count first
    count(100);
    count(240);
    rng(cf, 29, 31);
    rng(c0, 39, 41);
    rng(c1n, 39, 41);
    // Ratio four and a half, with slower reference and input dividers
    wr(12'h050, 32'h01);
    wr(12'h05c, 32'h02);
    wr(12'h070, 32'h02);
    wr(12'h074, 32'h03);
    wr(12'h0b4, 32'h05);
    rc(12'h044, 32'h04);
    rc(12'h050, 32'h01);
    rc(12'h05c, 32'h02);
    count(40);
    count(360);
    rng(cf, 39, 41);
    rng(c0, 9, 11);
    rng(c1n, 11, 13);
    wr(12'h054, 32'h3f);
    wr(12'h058, 32'hff);
    wr(12'h05c, 32'hff);
    rc(12'h054, 32'h3f);
    // Manual secondary select bypasses the reference divider
    wr(12'h07c, 32'h1f);
    count(360);
    rng(c0, 19, 21);
    wr(12'h07c, 32'h0f);
    // Primary doubler doubles the reference tick rate
    wr(12'h000, 32'h03);
    count(40);
    count(360);
    rng(c0, 19, 21);
    rng(c1n, 23, 25);
    // Soft reset keeps the bank; first calibration fails slowly, second succeeds
    wr(12'h008, 32'h5a);
    wr(12'h000, 32'h00);
    wait_for(0, 1'b0);
    fail <= 1'b1;
    slow <= 1'b1;
    wr(12'h000, 32'h01);
    wait_for(1, 1'b1);
    chk({24'h0, mute}, 32'h5a);
    wait_for(1, 1'b0);
    repeat (4) @(posedge clk);
    fail <= 1'b0;
    chk({30'h0, rel}, 32'h0);
    wait_for(1, 1'b1);
    wait_for(0, 1'b1);
    rc(12'h078, 32'h0a);
    bus(12'h004, 1'b0, 32'h0);
    chk(q & 32'hc3, 32'hc2);
    // Pin reset with supplies down: writes ignored, defaults back, no calibration
    power_down_n <= 1'b0;
    sup <= 1'b0;
    wr(12'h078, 32'h0f);
    chk({30'h0, rel}, 32'h0);
    power_down_n <= 1'b1;
    repeat (100) @(posedge clk);
    chk({30'h0, cst}, 32'h0);
    rc(12'h078, 32'h04);
    rc(12'h060, 32'h00);
    sup <= 1'b1;
    wait_for(1, 1'b1);
    wait_for(0, 1'b1);
    results;
  end
endmodule
`default_nettype wire
